// ===== dafh_defs.svh
/*
 digital audio port format handler: constants for offsets, field positions,
 reset values and timing counts. assumes a 10 mhz system clock.
*/
`ifndef DAFH_DEFS_SVH
`define DAFH_DEFS_SVH

// register byte offsets
`define DAFH_OFF_CTRL        8'h00
`define DAFH_OFF_RATE        8'h04
`define DAFH_OFF_STATUS      8'h08
`define DAFH_OFF_CS_LO       8'h0c
`define DAFH_OFF_CS_HI       8'h10

// control field positions
`define DAFH_CTRL_COAX_PRO   0
`define DAFH_CTRL_OPT_SPDIF  1
`define DAFH_CTRL_QUAD_SET   2
`define DAFH_CTRL_RESET      8'h00

// rate field codes
`define DAFH_RATE_RESET      3'h2

// channel status bits
`define DAFH_CS_PRO_BIT      0
`define DAFH_CS_AUDIO_BIT    1
`define DAFH_CS_EMPH_LSB     2

// detection timing
`define DAFH_DET_TIME_US     100
`define DAFH_CLK_MHZ         10
`define DAFH_DET_CYCLES      (`DAFH_DET_TIME_US * `DAFH_CLK_MHZ)

`endif

// ===== dafh_pkg.sv
/*
 digital audio port format handler: shared types.
 assumes dafh_defs.svh for numeric constants.
*/
package dafh_pkg;
    typedef enum logic [1:0] {
        DAFH_SPEED_SINGLE,
        DAFH_SPEED_DOUBLE,
        DAFH_SPEED_QUAD
    } dafh_speed_t;

    typedef enum logic {
        DAFH_OPT_LIGHTPIPE,
        DAFH_OPT_SPDIF
    } dafh_optfmt_t;

    typedef struct packed {
        logic        valid;
        logic [2:0]  slot;
        logic [23:0] data;
    } dafh_sample_t;

    typedef struct packed {
        logic        valid;
        logic        chan;
        logic [23:0] data;
        logic        cs_bit;
        logic        emphasis;
    } dafh_spdif_t;
endpackage : dafh_pkg

// ===== dafh_cs_gen.sv
/*
 channel status bit generator: walks a fresh 192 bit status block,
 one bit per frame, consumer or professional layout.
 assumes a one-cycle frame strobe from the owning transmitter.
*/
`timescale 1ns/1ns
`include "dafh_defs.svh"

module dafh_cs_gen #(
    parameter int BLOCK_LEN = 192
) (
    input  wire logic       i_clock,
    input  wire logic       i_rst_n,
    input  wire logic       i_frame,
    input  wire logic       i_pro,
    input  wire logic [2:0] i_rate,
    output logic            o_cs_bit,
    output logic            o_block_start
);
    typedef struct packed {
        logic [7:0] idx;
        logic       cs_bit;
        logic       start;
    } dafh_csg_state_t;

    dafh_csg_state_t st_reg;
    dafh_csg_state_t st_next;

    function automatic logic cs_value(input logic [7:0] idx, input logic pro, input logic [2:0] rate);
        logic v;
        v = 1'b0;
        if (idx == 8'h00) begin
            v = pro;
        end else if (pro && idx >= 8'h18 && idx <= 8'h1a) begin
            v = rate[idx[1:0]];
        end else if (!pro && idx >= 8'h18 && idx <= 8'h1a) begin
            v = rate[idx[1:0]];
        end
        return v;
    endfunction : cs_value

    always_comb begin
        st_next = st_reg;
        st_next.start = 1'b0;
        if (i_frame) begin
            st_next.cs_bit = cs_value(st_reg.idx, i_pro, i_rate);
            st_next.start  = (st_reg.idx == 8'h00);
            if (st_reg.idx == 8'(BLOCK_LEN - 1)) begin
                st_next.idx = 8'h00;
            end else begin
                st_next.idx = st_reg.idx + 8'h01;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_cs_bit      = st_reg.cs_bit;
    assign o_block_start = st_reg.start;
endmodule : dafh_cs_gen

// ===== dafh_port_format.sv
/*
 digital audio port format handler: format rules for the aes, coaxial
 and optical ports, register port, optical format detection, speed-mode
 slot mapping and fresh outgoing channel status.
 assumes decoded receiver frames on the same clock, one frame strobe shared
 by all transmit sides, and a one-cycle register strobe master.
*/
`timescale 1ns/1ns
`include "dafh_defs.svh"

module dafh_port_format #(
    parameter int DET_CYCLES = `DAFH_DET_CYCLES
) (
    input  wire logic                 i_clock,
    input  wire logic                 i_rst_n,
    // register port
    input  wire logic [7:0]           i_addr,
    input  wire logic [31:0]          i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic      [31:0]          o_rdata,
    // receivers
    input  wire dafh_pkg::dafh_spdif_t i_aes_rx,
    input  wire dafh_pkg::dafh_spdif_t i_coax_rx,
    input  wire dafh_pkg::dafh_spdif_t i_opt_spdif_rx,
    input  wire dafh_pkg::dafh_sample_t i_opt_lp_rx,
    input  wire logic                 i_opt_spdif_seen,
    input  wire logic                 i_opt_lp_seen,
    input  wire logic                 i_opt_ds_id,
    input  wire logic                 i_opt_lp_pin,
    // host side
    output dafh_pkg::dafh_sample_t    o_host_aes,
    output dafh_pkg::dafh_sample_t    o_host_coax,
    output dafh_pkg::dafh_sample_t    o_host_opt,
    output dafh_pkg::dafh_speed_t     o_speed,
    // transmitters
    input  wire dafh_pkg::dafh_sample_t i_host_tx_opt,
    input  wire dafh_pkg::dafh_sample_t i_host_tx_aes,
    input  wire dafh_pkg::dafh_sample_t i_host_tx_coax,
    input  wire logic                 i_tx_frame,
    output dafh_pkg::dafh_spdif_t     o_aes_tx,
    output dafh_pkg::dafh_spdif_t     o_coax_tx,
    output dafh_pkg::dafh_spdif_t     o_opt_spdif_tx,
    output dafh_pkg::dafh_sample_t    o_opt_lp_tx,
    output logic                      o_coax_hi_level,
    output logic                      o_opt_is_spdif_tx
);
    localparam int DET_W = $clog2(DET_CYCLES + 1);

    typedef struct packed {
        logic [7:0]              ctrl;
        logic [2:0]              rate;
        logic [31:0]             rdata;
        logic [1:0]              pin_sync;
        dafh_pkg::dafh_optfmt_t  opt_fmt;
        logic [DET_W-1:0]        det_cnt;
        logic                    ds_seen;
        dafh_pkg::dafh_speed_t   speed;
        logic [2:0]              tx_sub;
        dafh_pkg::dafh_sample_t  host_aes;
        dafh_pkg::dafh_sample_t  host_coax;
        dafh_pkg::dafh_sample_t  host_opt;
        dafh_pkg::dafh_spdif_t   aes_tx;
        dafh_pkg::dafh_spdif_t   coax_tx;
        dafh_pkg::dafh_spdif_t   opt_tx;
        dafh_pkg::dafh_sample_t  lp_tx;
        logic                    hi_level;
    } dafh_state_t;

    dafh_state_t st_reg;
    dafh_state_t st_next;

    logic cs_pro_bit;
    logic cs_con_bit;

    // speed code to number of logical channels minus one
    function automatic logic [2:0] chan_limit(input dafh_pkg::dafh_speed_t sp);
        logic [2:0] v;
        unique case (sp)
            dafh_pkg::DAFH_SPEED_SINGLE: v = 3'h7;
            dafh_pkg::DAFH_SPEED_DOUBLE: v = 3'h3;
            dafh_pkg::DAFH_SPEED_QUAD:   v = 3'h1;
            default:                     v = 3'h7;
        endcase
        return v;
    endfunction : chan_limit

    // physical slot to logical channel: consecutive slots per channel
    function automatic logic [2:0] slot_to_chan(input logic [2:0] slot, input dafh_pkg::dafh_speed_t sp);
        logic [2:0] v;
        unique case (sp)
            dafh_pkg::DAFH_SPEED_SINGLE: v = slot;
            dafh_pkg::DAFH_SPEED_DOUBLE: v = {1'b0, slot[2:1]};
            dafh_pkg::DAFH_SPEED_QUAD:   v = {2'b00, slot[2]};
            default:                     v = slot;
        endcase
        return v;
    endfunction : slot_to_chan

    function automatic dafh_pkg::dafh_sample_t strip_rx(input dafh_pkg::dafh_spdif_t rx);
        dafh_pkg::dafh_sample_t s;
        s.valid = rx.valid;
        s.slot  = {2'b00, rx.chan};
        s.data  = rx.data;
        return s;
    endfunction : strip_rx

    dafh_cs_gen #(
        .BLOCK_LEN (192)
    ) u_cs_pro (
        .i_clock       (i_clock),
        .i_rst_n       (i_rst_n),
        .i_frame       (i_tx_frame),
        .i_pro         (st_reg.ctrl[`DAFH_CTRL_COAX_PRO]),
        .i_rate        (st_reg.rate),
        .o_cs_bit      (cs_pro_bit),
        .o_block_start ()
    );

    dafh_cs_gen #(
        .BLOCK_LEN (192)
    ) u_cs_con (
        .i_clock       (i_clock),
        .i_rst_n       (i_rst_n),
        .i_frame       (i_tx_frame),
        .i_pro         (1'b0),
        .i_rate        (st_reg.rate),
        .o_cs_bit      (cs_con_bit),
        .o_block_start ()
    );

    always_comb begin
        st_next = st_reg;
        st_next.pin_sync = {st_reg.pin_sync[0], i_opt_lp_pin};

        // register port
        if (i_wr) begin
            unique case (i_addr)
                `DAFH_OFF_CTRL: st_next.ctrl = i_wdata[7:0];
                `DAFH_OFF_RATE: st_next.rate = i_wdata[2:0];
                default: ;
            endcase
        end
        st_next.rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                `DAFH_OFF_CTRL:   st_next.rdata = {24'h000000, st_reg.ctrl};
                `DAFH_OFF_RATE:   st_next.rdata = {29'h0, st_reg.rate};
                `DAFH_OFF_STATUS: st_next.rdata = {27'h0, st_reg.pin_sync[1], st_reg.ds_seen,
                                                   st_reg.speed, st_reg.opt_fmt};
                default:          st_next.rdata = '0;
            endcase
        end

        // optical format detection, spdif wins on its own
        if (i_opt_spdif_seen) begin
            st_next.opt_fmt = dafh_pkg::DAFH_OPT_SPDIF;
            st_next.det_cnt = '0;
        end else if (i_opt_lp_seen) begin
            if (st_reg.det_cnt == DET_W'(DET_CYCLES)) begin
                st_next.opt_fmt = dafh_pkg::DAFH_OPT_LIGHTPIPE;
            end else begin
                st_next.det_cnt = st_reg.det_cnt + DET_W'(1);
            end
        end else begin
            // lightpipe presence must be unbroken
            st_next.det_cnt = '0;
        end
        st_next.ds_seen = i_opt_ds_id && st_reg.opt_fmt == dafh_pkg::DAFH_OPT_LIGHTPIPE;

        // speed mode from id, rate setting, or explicit quad
        if (st_reg.ctrl[`DAFH_CTRL_QUAD_SET] || st_reg.rate[2]) begin
            st_next.speed = dafh_pkg::DAFH_SPEED_QUAD;
        end else if (st_reg.ds_seen || st_reg.rate[1]) begin
            st_next.speed = dafh_pkg::DAFH_SPEED_DOUBLE;
        end else begin
            st_next.speed = dafh_pkg::DAFH_SPEED_SINGLE;
        end

        // independent inputs, status and emphasis stripped
        st_next.host_aes  = strip_rx(i_aes_rx);
        st_next.host_coax = strip_rx(i_coax_rx);

        // optical receive mapping
        st_next.host_opt.valid = 1'b0;
        if (st_reg.opt_fmt == dafh_pkg::DAFH_OPT_SPDIF) begin
            st_next.host_opt = strip_rx(i_opt_spdif_rx);
        end else if (i_opt_lp_rx.valid) begin
            st_next.host_opt.valid = slot_to_chan(i_opt_lp_rx.slot, st_reg.speed)
                                     <= chan_limit(st_reg.speed);
            st_next.host_opt.slot  = slot_to_chan(i_opt_lp_rx.slot, st_reg.speed);
            st_next.host_opt.data  = i_opt_lp_rx.data;
        end

        // transmit sides, fresh status on every spdif output
        st_next.aes_tx.valid    = i_host_tx_aes.valid;
        st_next.aes_tx.chan     = i_host_tx_aes.slot[0];
        st_next.aes_tx.data     = i_host_tx_aes.data;
        st_next.aes_tx.cs_bit   = cs_pro_bit;
        st_next.aes_tx.emphasis = 1'b0;

        st_next.coax_tx.valid    = i_host_tx_coax.valid;
        st_next.coax_tx.chan     = i_host_tx_coax.slot[0];
        st_next.coax_tx.data     = i_host_tx_coax.data;
        st_next.coax_tx.cs_bit   = cs_pro_bit;
        st_next.coax_tx.emphasis = 1'b0;
        st_next.hi_level = st_reg.ctrl[`DAFH_CTRL_COAX_PRO];

        st_next.opt_tx.valid = 1'b0;
        st_next.lp_tx.valid  = 1'b0;
        if (st_reg.ctrl[`DAFH_CTRL_OPT_SPDIF]) begin
            st_next.opt_tx.valid    = i_host_tx_opt.valid && i_host_tx_opt.slot <= 3'h1;
            st_next.opt_tx.chan     = i_host_tx_opt.slot[0];
            st_next.opt_tx.data     = i_host_tx_opt.data;
            st_next.opt_tx.cs_bit   = cs_con_bit;
            st_next.opt_tx.emphasis = 1'b0;
        end else if (i_host_tx_opt.valid && i_host_tx_opt.slot <= chan_limit(st_reg.speed)) begin
            st_next.lp_tx.valid = 1'b1;
            st_next.lp_tx.data  = i_host_tx_opt.data;
            // logical channel c with sample k goes to slot c*n+k
            unique case (st_reg.speed)
                dafh_pkg::DAFH_SPEED_SINGLE: st_next.lp_tx.slot = i_host_tx_opt.slot;
                dafh_pkg::DAFH_SPEED_DOUBLE: st_next.lp_tx.slot = {i_host_tx_opt.slot[1:0], st_reg.tx_sub[0]};
                dafh_pkg::DAFH_SPEED_QUAD:   st_next.lp_tx.slot = {i_host_tx_opt.slot[0], st_reg.tx_sub[1:0]};
                default:                     st_next.lp_tx.slot = i_host_tx_opt.slot;
            endcase
        end
        if (i_tx_frame) begin
            st_next.tx_sub = st_reg.tx_sub + 3'h1;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg      <= '0;
            st_reg.ctrl <= `DAFH_CTRL_RESET;
            st_reg.rate <= `DAFH_RATE_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_rdata           = st_reg.rdata;
    assign o_host_aes        = st_reg.host_aes;
    assign o_host_coax       = st_reg.host_coax;
    assign o_host_opt        = st_reg.host_opt;
    assign o_speed           = st_reg.speed;
    assign o_aes_tx          = st_reg.aes_tx;
    assign o_coax_tx         = st_reg.coax_tx;
    assign o_opt_spdif_tx    = st_reg.opt_tx;
    assign o_opt_lp_tx       = st_reg.lp_tx;
    assign o_coax_hi_level   = st_reg.hi_level;
    assign o_opt_is_spdif_tx = st_reg.ctrl[`DAFH_CTRL_OPT_SPDIF];
endmodule : dafh_port_format

// ===== dafh_pf_sva.sv
/*
 port-level assertions for the digital audio port format handler.
 assumes a single clock domain and binding onto dafh_port_format.
*/
`timescale 1ns/1ns
`include "dafh_defs.svh"

module dafh_pf_sva (
    input wire logic                   i_clock,
    input wire logic                   i_rst_n,
    input wire logic [7:0]             i_addr,
    input wire logic [31:0]            i_wdata,
    input wire logic                   i_wr,
    input wire logic                   i_rd,
    input wire logic [31:0]            o_rdata,
    input wire dafh_pkg::dafh_spdif_t  i_aes_rx,
    input wire dafh_pkg::dafh_spdif_t  i_coax_rx,
    input wire dafh_pkg::dafh_sample_t i_opt_lp_rx,
    input wire dafh_pkg::dafh_sample_t i_host_tx_opt,
    input wire dafh_pkg::dafh_sample_t o_host_aes,
    input wire dafh_pkg::dafh_sample_t o_host_coax,
    input wire dafh_pkg::dafh_sample_t o_host_opt,
    input wire dafh_pkg::dafh_speed_t  o_speed,
    input wire dafh_pkg::dafh_spdif_t  o_aes_tx,
    input wire dafh_pkg::dafh_spdif_t  o_coax_tx,
    input wire dafh_pkg::dafh_spdif_t  o_opt_spdif_tx,
    input wire dafh_pkg::dafh_sample_t o_opt_lp_tx,
    input wire logic                   o_coax_hi_level,
    input wire logic                   o_opt_is_spdif_tx
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    sequence s_ctrl_wr;
        i_wr && i_addr == `DAFH_OFF_CTRL;
    endsequence
    AST_RD_IDLE: assert property (!$past(i_rd) |-> o_rdata == 32'h0) else $error("read data not idle");
    AST_EMPH_ZERO: assert property (!o_aes_tx.emphasis && !o_coax_tx.emphasis && !o_opt_spdif_tx.emphasis)
        else $error("emphasis sent");
    AST_AES_RX: assert property (i_aes_rx.valid |=> o_host_aes.valid && o_host_aes.data == $past(i_aes_rx.data))
        else $error("aes sample lost");
    AST_COAX_RX: assert property (i_coax_rx.valid |=> o_host_coax.valid && o_host_coax.data == $past(i_coax_rx.data))
        else $error("coax sample lost");
    AST_LP_DOUBLE: assert property (i_opt_lp_rx.valid && o_speed == dafh_pkg::DAFH_SPEED_DOUBLE |=>
        o_host_opt.valid && o_host_opt.slot == ($past(i_opt_lp_rx.slot) >> 1)) else $error("double slot map");
    AST_LP_QUAD: assert property (i_opt_lp_rx.valid && o_speed == dafh_pkg::DAFH_SPEED_QUAD |=>
        o_host_opt.valid && o_host_opt.slot == ($past(i_opt_lp_rx.slot) >> 2)) else $error("quad slot map");
    AST_COAX_PRO: assert property (s_ctrl_wr |-> ##2 o_coax_hi_level == $past(i_wdata[0], 2))
        else $error("coax level wrong");
    AST_FORCE_QUAD: assert property (s_ctrl_wr ##0 i_wdata[2] |-> ##2 o_speed == dafh_pkg::DAFH_SPEED_QUAD)
        else $error("quad not forced");
    AST_OPT_SPDIF_SLOT: assert property (o_opt_is_spdif_tx && i_host_tx_opt.valid && i_host_tx_opt.slot > 3'h1
        |=> !o_opt_spdif_tx.valid) else $error("optical spdif sent high slot");
    AST_LP_TX_SINGLE: assert property (!o_opt_is_spdif_tx && i_host_tx_opt.valid &&
        o_speed == dafh_pkg::DAFH_SPEED_SINGLE |=> o_opt_lp_tx.valid && o_opt_lp_tx.slot == $past(i_host_tx_opt.slot))
        else $error("lightpipe tx slot");
endmodule : dafh_pf_sva

bind dafh_port_format dafh_pf_sva u_sva (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_aes_rx(i_aes_rx), .i_coax_rx(i_coax_rx), .i_opt_lp_rx(i_opt_lp_rx),
    .i_host_tx_opt(i_host_tx_opt), .o_host_aes(o_host_aes), .o_host_coax(o_host_coax), .o_host_opt(o_host_opt),
    .o_speed(o_speed), .o_aes_tx(o_aes_tx), .o_coax_tx(o_coax_tx), .o_opt_spdif_tx(o_opt_spdif_tx),
    .o_opt_lp_tx(o_opt_lp_tx), .o_coax_hi_level(o_coax_hi_level), .o_opt_is_spdif_tx(o_opt_is_spdif_tx)
);

// ===== dafh_ext_gear.sv
/*
 external audio gear model: sends one decoded sample on chosen ports.
 assumes send requests from the bench, one clock.
*/
`timescale 1ns/1ns

module dafh_ext_gear (
    input  wire logic                   i_clock,
    input  wire logic [3:0]             i_send,
    input  wire logic [2:0]             i_slot,
    input  wire logic [23:0]            i_data,
    output dafh_pkg::dafh_spdif_t       o_aes = '0,
    output dafh_pkg::dafh_spdif_t       o_coax = '0,
    output dafh_pkg::dafh_spdif_t       o_opt_spdif = '0,
    output dafh_pkg::dafh_sample_t      o_opt_lp = '0
);
    logic [23:0] last_q = 24'h0;
    logic [23:0] dat;
    // idle lines show the inverse of the last sample
    assign dat = (|i_send) ? i_data : ~last_q;
    // status and emphasis always set so they must be ignored
    always_ff @(posedge i_clock) begin
        if (|i_send) last_q <= i_data;
        o_aes       <= '{i_send[0], i_slot[0], dat, 1'b1, 1'b1};
        o_coax      <= '{i_send[1], i_slot[0], dat, 1'b1, 1'b1};
        o_opt_spdif <= '{i_send[2], i_slot[0], dat, 1'b1, 1'b1};
        o_opt_lp    <= '{i_send[3], i_slot, dat};
    end
endmodule : dafh_ext_gear

// ===== dafh_port_format_bench.sv
/*
 self-checking bench for the port format handler.
 assumes the checker is bound and the gear model drives the receivers.
*/
`timescale 1ns/1ns
`include "dafh_defs.svh"

module dafh_port_format_bench;
    logic clock = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, sp_seen = 1'b0, lp_seen = 1'b0, ds_id = 1'b0;
    logic tx_frame = 1'b0, lp_pin = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] snd_en = 4'h0;
    logic [2:0] pslot = 3'h0;
    logic [23:0] pdata = 24'h0;
    int error_cnt = 0, samples_checked = 0;
    dafh_pkg::dafh_sample_t htx = '0, h_aes, h_coax, h_opt, lp_tx;
    dafh_pkg::dafh_spdif_t r_aes, r_coax, r_opt, t_aes, t_coax, t_opt;
    dafh_pkg::dafh_sample_t r_lp;
    dafh_pkg::dafh_speed_t speed;
    logic hi_lvl, opt_sp;

    dafh_ext_gear u_gear (.i_clock(clock), .i_send(snd_en), .i_slot(pslot), .i_data(pdata),
        .o_aes(r_aes), .o_coax(r_coax), .o_opt_spdif(r_opt), .o_opt_lp(r_lp));
    dafh_port_format #(.DET_CYCLES(4)) u_dut (.i_clock(clock), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_aes_rx(r_aes), .i_coax_rx(r_coax), .i_opt_spdif_rx(r_opt),
        .i_opt_lp_rx(r_lp), .i_opt_spdif_seen(sp_seen), .i_opt_lp_seen(lp_seen), .i_opt_ds_id(ds_id),
        .i_opt_lp_pin(lp_pin), .o_host_aes(h_aes), .o_host_coax(h_coax), .o_host_opt(h_opt), .o_speed(speed),
        .i_host_tx_opt(htx), .i_host_tx_aes(htx), .i_host_tx_coax(htx), .i_tx_frame(tx_frame),
        .o_aes_tx(t_aes), .o_coax_tx(t_coax), .o_opt_spdif_tx(t_opt), .o_opt_lp_tx(lp_tx),
        .o_coax_hi_level(hi_lvl), .o_opt_is_spdif_tx(opt_sp));

    initial begin
        forever #50 clock = ~clock;
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock) begin addr <= a; wdata <= v; wr <= 1'b1; end
        @(posedge clock) wr <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock) begin addr <= a; rd <= 1'b1; end
        @(posedge clock) rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    task send(input logic [3:0] en, input logic [2:0] s, input logic [23:0] v);
        @(posedge clock) begin snd_en <= en; pslot <= s; pdata <= v; end
        @(posedge clock) snd_en <= 4'h0;
        @(posedge clock) #1;
    endtask : send

    task txs(input logic [2:0] s, input logic [23:0] v);
        @(posedge clock) htx <= '{1'b1, s, v};
        @(posedge clock) htx.valid <= 1'b0;
        #1;
    endtask : txs

    task frame;
        @(posedge clock) tx_frame <= 1'b1;
        @(posedge clock) tx_frame <= 1'b0;
    endtask : frame

    task t_regs;
        rd_reg(`DAFH_OFF_CTRL, d); chk(d, 32'h0);
        rd_reg(`DAFH_OFF_RATE, d); chk(d, 32'h2);
        wr_reg(8'h40, 32'hffffffff);
        rd_reg(8'h40, d); chk(d, 32'h0);
        wr_reg(`DAFH_OFF_RATE, 32'h0);
        rd_reg(`DAFH_OFF_RATE, d); chk(d, 32'h0);
    endtask : t_regs

    task t_rx;
        send(4'h3, 3'h0, 24'h5a3c96);
        chk({h_aes.valid, h_aes.data}, {1'b1, 24'h5a3c96});
        chk({h_coax.valid, h_coax.data}, {1'b1, 24'h5a3c96});
    endtask : t_rx

    task t_detect;
        @(posedge clock) begin sp_seen <= 1'b1; lp_pin <= 1'b1; end
        @(posedge clock) sp_seen <= 1'b0;
        rd_reg(`DAFH_OFF_STATUS, d); chk(d[0], 1'b1);
        chk(d[4], 1'b1);
        send(4'h4, 3'h1, 24'h123456);
        chk({h_opt.valid, h_opt.slot, h_opt.data}, {1'b1, 3'h1, 24'h123456});
        @(posedge clock) lp_seen <= 1'b1;
        repeat (6) @(posedge clock);
        lp_seen <= 1'b0;
        rd_reg(`DAFH_OFF_STATUS, d); chk(d[0], 1'b0);
    endtask : t_detect

    task t_speed;
        chk(speed, dafh_pkg::DAFH_SPEED_SINGLE);
        @(posedge clock) begin ds_id <= 1'b1; lp_pin <= 1'b0; end
        repeat (3) @(posedge clock);
        rd_reg(`DAFH_OFF_STATUS, d); chk(d[4:1], 4'b0101);
        send(4'h8, 3'h3, 24'h0f0f0f);
        chk({h_opt.valid, h_opt.slot}, {1'b1, 3'h1});
        wr_reg(`DAFH_OFF_CTRL, 32'h4);
        @(posedge clock) #1 chk(speed, dafh_pkg::DAFH_SPEED_QUAD);
        send(4'h8, 3'h6, 24'h00ff00);
        chk({h_opt.valid, h_opt.slot}, {1'b1, 3'h1});
    endtask : t_speed

    task t_tx;
        @(posedge clock) ds_id <= 1'b0;
        wr_reg(`DAFH_OFF_CTRL, 32'h3);
        @(posedge clock) #1 chk({hi_lvl, opt_sp}, 2'b11);
        frame();
        txs(3'h0, 24'habcdef);
        chk({t_opt.valid, t_opt.data, t_opt.emphasis}, {1'b1, 24'habcdef, 1'b0});
        chk({t_coax.valid, t_coax.data}, {1'b1, 24'habcdef});
        chk({t_aes.valid, t_aes.data, t_aes.emphasis}, {1'b1, 24'habcdef, 1'b0});
        chk({t_coax.cs_bit, t_aes.cs_bit, t_opt.cs_bit}, 3'b110);
        txs(3'h2, 24'h111111);
        chk(t_opt.valid, 1'b0);
        wr_reg(`DAFH_OFF_CTRL, 32'h0);
        frame();
        #1 chk({hi_lvl, speed}, {1'b0, dafh_pkg::DAFH_SPEED_SINGLE});
        txs(3'h5, 24'h777777);
        chk({lp_tx.valid, lp_tx.slot, lp_tx.data}, {1'b1, 3'h5, 24'h777777});
        wr_reg(`DAFH_OFF_RATE, 32'h2);
        @(posedge clock) #1 chk(speed, dafh_pkg::DAFH_SPEED_DOUBLE);
        // two frames sent so far: channel 1, sample 0 goes to slot 2
        txs(3'h1, 24'h2468ac);
        chk({lp_tx.valid, lp_tx.slot, lp_tx.data}, {1'b1, 3'h2, 24'h2468ac});
        txs(3'h5, 24'h13579b);
        chk(lp_tx.valid, 1'b0);
    endtask : t_tx

    task results;
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    initial begin
        #(100 * 3000);
        error_cnt++;
        $display("[FAIL] %0t watchdog expired", $time);
        results();
    end

    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        t_regs();
        t_rx();
        t_detect();
        t_speed();
        t_tx();
        results();
    end
endmodule : dafh_port_format_bench
